/* verilog/ihcp_pkg.sv */
// Purpose: Shared constants and types of the serial host control port.
// Assumes: Byte-wide transfers, 7-bit bus address.
// Notes: Strap levels that select serial mode are set here.
package ihcp_pkg;

   localparam int IHCP_BYTE_W = 8;
   localparam int IHCP_ADDR_W = 7;
   localparam int IHCP_FIFO_DEPTH = 16;
   localparam logic [2:0] IHCP_BIT_LAST = 3'h7;
   localparam logic [6:0] IHCP_OWN_ADDR_RST = 7'h00;
   localparam logic IHCP_CHECK_EN_RST = 1'b1;
   localparam logic IHCP_SERIAL_OE_LEVEL = 1'b1;
   localparam logic IHCP_SERIAL_WR_LEVEL = 1'b1;
   localparam logic [1:0] IHCP_STRAP_WAIT = 2'h3;
   localparam logic [7:0] IHCP_IDLE_BYTE = 8'hFF;

   typedef enum logic [2:0] {
      IHCP_IDLE     = 3'b000,
      IHCP_ADDR     = 3'b001,
      IHCP_ADDR_ACK = 3'b010,
      IHCP_WR_DATA  = 3'b011,
      IHCP_WR_ACK   = 3'b100,
      IHCP_RD_DATA  = 3'b101,
      IHCP_RD_ACK   = 3'b110,
      IHCP_IGNORE   = 3'b111
   } ihcp_phase_t;

   typedef struct packed {
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic [2:0] oe_sync;
      logic [2:0] wr_sync;
      logic [2:0] boot_sync;
      logic scl_f;
      logic sda_f;
      logic [1:0] strap_cnt;
      logic strap_done;
      logic serial_mode;
      logic autoload_req;
      logic [6:0] own_addr;
      logic check_en;
      ihcp_phase_t phase;
      logic [2:0] bit_cnt;
      logic [7:0] shreg;
      logic is_read;
      logic ack_en;
      logic ack_rise;
      logic sda_drv;
      logic loaded;
      logic hold_rel;
      logic req_drv;
   } ihcp_regs_t;

   // Link synchronisers start at the idle high level so no false edge follows reset
   localparam ihcp_regs_t IHCP_REGS_RST = '{
      scl_sync: 3'h7,
      sda_sync: 3'h7,
      own_addr: IHCP_OWN_ADDR_RST,
      check_en: IHCP_CHECK_EN_RST,
      phase: IHCP_IDLE,
      scl_f: 1'b1,
      sda_f: 1'b1,
      default: '0
   };

endpackage

/* verilog/ihcp_fifo.sv */
// Purpose: Receive FIFO between the serial port and the DSP side.
// Assumes: DEPTH is a power of two.
// Notes: Read data come out of a register; one word of look-ahead.
`timescale 1ns/100ps
module ihcp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   // Fill side
   input wire logic [WIDTH-1:0] in_data_in,
   input wire logic in_valid_in,
   output logic in_ready_out,
   // Drain side
   output logic [WIDTH-1:0] out_data_out,
   output logic out_valid_out,
   input wire logic out_ready_in
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
      logic [WIDTH-1:0] out_data;
      logic out_valid;
   } ihcp_fifo_t;

   ihcp_fifo_t q;
   ihcp_fifo_t d;
   logic push;
   logic pop;

   assign in_ready_out = q.count < (AW+1)'(DEPTH);
   assign out_data_out = q.out_data;
   assign out_valid_out = q.out_valid;

   always_comb begin
      d = q;
      push = in_valid_in && in_ready_out;
      pop = (q.count != '0) && (!q.out_valid || out_ready_in);
      if (out_ready_in && q.out_valid) begin
         d.out_valid = 1'b0;
      end
      if (push) begin
         d.mem[q.wr_ptr] = in_data_in;
         d.wr_ptr = q.wr_ptr + 1'b1;
      end
      if (pop) begin
         d.out_data = q.mem[q.rd_ptr];
         d.out_valid = 1'b1;
         d.rd_ptr = q.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         d.count = q.count + 1'b1;
      end else if (pop && !push) begin
         d.count = q.count - 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         q <= '0;
      end else if (ce_in) begin
         q <= d;
      end
   end

endmodule

/* verilog/ihcp_top.sv */
// Purpose: Two-wire slave control port: host writes bytes in, reads bytes out on request.
// Assumes: Serial clock and data are sampled by clk_in; host clocks far slower than clk_in.
// Notes: Data pin and request pin are open drain, each as output plus active-low enable.
`timescale 1ns/100ps
module ihcp_top
   import ihcp_pkg::*;
#(
   parameter int FIFO_DEPTH = IHCP_FIFO_DEPTH
) (
   // Clock, reset, enable
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ce_in,
   // Serial link
   input wire logic serial_ctrl_clock_in,
   input wire logic serial_ctrl_data_io_in,
   output logic serial_ctrl_data_io_out,
   output logic serial_ctrl_data_io_oe_n_out,
   // Read request pin
   output logic host_read_request_n_out,
   output logic host_read_request_n_oe_n_out,
   // Straps and autoload
   input wire logic mode_strap_output_enable_in,
   input wire logic mode_strap_write_strobe_in,
   input wire logic autoload_select_n_in,
   input wire logic autoload_done_in,
   output logic serial_mode_out,
   output logic autoload_active_out,
   // Address configuration
   input wire logic cfg_write_in,
   input wire logic cfg_check_en_in,
   input wire logic [IHCP_ADDR_W-1:0] cfg_addr_in,
   // Received bytes toward the DSP
   output logic [IHCP_BYTE_W-1:0] rx_data_out,
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   // Outbound bytes from the DSP
   input wire logic [IHCP_BYTE_W-1:0] tx_data_in,
   input wire logic tx_valid_in,
   output logic tx_ready_out
);

   ihcp_regs_t q;
   ihcp_regs_t d;

   logic [1:0] scl_edge;
   logic [1:0] sda_edge;
   logic scl_rise;
   logic scl_fall;
   logic sda_rise;
   logic sda_fall;
   logic bus_start;
   logic bus_stop;
   logic port_on;
   logic do_load;
   logic tx_take;
   logic push;
   logic [IHCP_BYTE_W-1:0] rx_byte;
   logic fifo_ready;

   // Settled edge of a three-stage synchronised input: {rise, fall}
   function automatic logic [1:0] edge_of(input logic [2:0] s, input logic f);
      logic agree;
      agree = s[1] == s[2];
      edge_of = {agree & s[2] & ~f, agree & ~s[2] & f};
   endfunction

   function automatic logic addr_match(input logic [6:0] rx, input logic [6:0] own, input logic chk);
      addr_match = !chk || (rx == own);
   endfunction

   assign scl_edge = edge_of(q.scl_sync, q.scl_f);
   assign sda_edge = edge_of(q.sda_sync, q.sda_f);
   assign scl_rise = scl_edge[1];
   assign scl_fall = scl_edge[0];
   assign sda_rise = sda_edge[1];
   assign sda_fall = sda_edge[0];

   assign bus_start = sda_fall && q.scl_f && !scl_fall;
   assign bus_stop = sda_rise && q.scl_f && !scl_fall;

   assign port_on = q.strap_done && q.serial_mode && !q.autoload_req;

   assign rx_byte = {q.shreg[6:0], q.sda_f};

   always_comb begin
      d = q;
      do_load = 1'b0;
      tx_take = 1'b0;
      push = 1'b0;

      d.scl_sync = {q.scl_sync[1:0], serial_ctrl_clock_in};
      d.sda_sync = {q.sda_sync[1:0], serial_ctrl_data_io_in};
      d.oe_sync = {q.oe_sync[1:0], mode_strap_output_enable_in};
      d.wr_sync = {q.wr_sync[1:0], mode_strap_write_strobe_in};
      d.boot_sync = {q.boot_sync[1:0], autoload_select_n_in};
      if (scl_rise || scl_fall) begin
         d.scl_f = q.scl_sync[2];
      end
      if (sda_rise || sda_fall) begin
         d.sda_f = q.sda_sync[2];
      end

      // straps caught once after reset release
      if (!q.strap_done) begin
         if (q.strap_cnt != IHCP_STRAP_WAIT) begin
            d.strap_cnt = q.strap_cnt + 1'b1;
         end else if (q.oe_sync[1] == q.oe_sync[2] && q.wr_sync[1] == q.wr_sync[2]
                      && q.boot_sync[1] == q.boot_sync[2]) begin
            d.strap_done = 1'b1;
            d.serial_mode = (q.oe_sync[2] == IHCP_SERIAL_OE_LEVEL) && (q.wr_sync[2] == IHCP_SERIAL_WR_LEVEL);
            d.autoload_req = !q.boot_sync[2] && d.serial_mode;
         end
      end else if (autoload_done_in) begin
         d.autoload_req = 1'b0;
      end

      if (cfg_write_in) begin
         d.own_addr = cfg_addr_in;
         d.check_en = cfg_check_en_in;
      end

      if (!port_on) begin
         d.phase = IHCP_IDLE;
         d.sda_drv = 1'b0;
         d.loaded = 1'b0;
         d.hold_rel = 1'b0;
      end else if (bus_start) begin
         d.phase = IHCP_ADDR;
         d.bit_cnt = '0;
         d.sda_drv = 1'b0;
         d.ack_rise = 1'b0;
         d.loaded = 1'b0;
         d.hold_rel = 1'b0;
      end else if (bus_stop) begin
         d.phase = IHCP_IDLE;
         d.sda_drv = 1'b0;
         d.ack_rise = 1'b0;
         d.loaded = 1'b0;
         d.hold_rel = 1'b0;
      end else begin
         case (q.phase)
            IHCP_ADDR, IHCP_WR_DATA: begin
               // bits shifted in on rising serial clock
               if (scl_rise) begin
                  d.shreg = rx_byte;
                  d.bit_cnt = q.bit_cnt + 1'b1;
                  if (q.bit_cnt == IHCP_BIT_LAST) begin
                     d.ack_rise = 1'b0;
                     if (q.phase == IHCP_ADDR) begin
                        if (addr_match(rx_byte[7:1], q.own_addr, q.check_en)) begin
                           d.phase = IHCP_ADDR_ACK;
                           d.ack_en = 1'b1;
                           d.is_read = rx_byte[0];
                        end else begin
                           d.phase = IHCP_IGNORE;
                        end
                     end else begin
                        // a whole byte goes to the FIFO only if it has room, else no acknowledge
                        d.phase = IHCP_WR_ACK;
                        d.ack_en = fifo_ready;
                        push = fifo_ready;
                     end
                  end
               end
            end
            IHCP_ADDR_ACK, IHCP_WR_ACK: begin
               if (scl_fall && !q.ack_rise) begin
                  // acknowledge held low for one serial clock
                  d.sda_drv = q.ack_en;
               end
               if (scl_rise) begin
                  d.ack_rise = 1'b1;
               end
               if (scl_fall && q.ack_rise) begin
                  d.sda_drv = 1'b0;
                  d.ack_rise = 1'b0;
                  d.bit_cnt = '0;
                  // read data only after address acknowledge
                  if (q.phase == IHCP_ADDR_ACK && q.is_read) begin
                     do_load = 1'b1;
                  end else begin
                     // a refused byte may simply be sent again
                     d.phase = IHCP_WR_DATA;
                  end
               end
            end
            IHCP_RD_DATA: begin
               // next bit placed on falling serial clock
               if (scl_fall) begin
                  d.shreg = {q.shreg[6:0], 1'b1};
                  d.sda_drv = !q.shreg[6];
               end
               if (scl_rise) begin
                  d.bit_cnt = q.bit_cnt + 1'b1;
                  if (q.bit_cnt == IHCP_BIT_LAST) begin
                     d.phase = IHCP_RD_ACK;
                     d.ack_rise = 1'b0;
                     d.loaded = 1'b0;
                     d.hold_rel = !tx_valid_in;
                  end
               end
            end
            IHCP_RD_ACK: begin
               if (scl_fall && !q.ack_rise) begin
                  // host owns the line for its acknowledge
                  d.sda_drv = 1'b0;
               end
               if (scl_rise) begin
                  d.ack_rise = 1'b1;
                  d.ack_en = !q.sda_f;
                  // hold ends at acknowledge rising edge
                  d.hold_rel = 1'b0;
               end
               if (scl_fall && q.ack_rise) begin
                  d.ack_rise = 1'b0;
                  d.bit_cnt = '0;
                  // host keeps reading while it acknowledges
                  if (q.ack_en) begin
                     do_load = 1'b1;
                  end else begin
                     d.phase = IHCP_IGNORE;
                  end
               end
            end
            IHCP_IDLE, IHCP_IGNORE: begin
               d.sda_drv = 1'b0;
            end
            default: begin
               d.phase = IHCP_IDLE;
               d.sda_drv = 1'b0;
            end
         endcase
      end

      if (do_load) begin
         d.phase = IHCP_RD_DATA;
         if (tx_valid_in) begin
            d.shreg = tx_data_in;
            d.loaded = 1'b1;
            tx_take = ce_in;
         end else begin
            d.shreg = IHCP_IDLE_BYTE;
            d.loaded = 1'b0;
         end
         // one line, the port drives only zeros
         d.sda_drv = !d.shreg[7];
      end

      // request low while outbound data waits
      d.req_drv = port_on && !d.hold_rel && (d.loaded || tx_valid_in);
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         q <= IHCP_REGS_RST;
      end else if (ce_in) begin
         q <= d;
      end
   end

   ihcp_fifo #(
      .WIDTH(IHCP_BYTE_W),
      .DEPTH(FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .ce_in(ce_in),
      .in_data_in(rx_byte),
      .in_valid_in(push && ce_in),
      .in_ready_out(fifo_ready),
      .out_data_out(rx_data_out),
      .out_valid_out(rx_valid_out),
      .out_ready_in(rx_ready_in)
   );

   assign serial_ctrl_data_io_out = 1'b0;
   assign serial_ctrl_data_io_oe_n_out = !q.sda_drv;
   assign host_read_request_n_out = 1'b0;
   assign host_read_request_n_oe_n_out = !q.req_drv;
   assign serial_mode_out = q.strap_done && q.serial_mode;
   assign autoload_active_out = q.autoload_req;
   assign tx_ready_out = tx_take;

endmodule

/* bench/ihcp_top_monitor.sv */
// Purpose: Port checks of the serial host control port.
// Assumes: One clock domain; host serial clock far slower than clk_in.
// Notes: Bound into ihcp_top.
`timescale 1ns/100ps
module ihcp_top_monitor
   import ihcp_pkg::*;
#(
   parameter int FIFO_DEPTH = IHCP_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Link pins
   input wire logic serial_ctrl_clock_in,
   input wire logic serial_ctrl_data_io_oe_n_out,
   input wire logic host_read_request_n_oe_n_out,
   // Mode and byte streams
   input wire logic serial_mode_out,
   input wire logic autoload_active_out,
   input wire logic [IHCP_BYTE_W-1:0] rx_data_out,
   input wire logic rx_valid_out,
   input wire logic rx_ready_in,
   input wire logic tx_valid_in,
   input wire logic tx_ready_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   chk_reset_release: assert property (disable iff (1'b0) reset_in |=>
      serial_ctrl_data_io_oe_n_out && host_read_request_n_oe_n_out && !rx_valid_out && !serial_mode_out)
      else $error("outputs not released by reset");
   chk_ack_length: assert property ($fell(serial_ctrl_data_io_oe_n_out) |->
      !serial_ctrl_data_io_oe_n_out [*6]) else $error("data drive shorter than a bit");
   chk_drive_scl_low: assert property ($changed(serial_ctrl_data_io_oe_n_out) |->
      !$past(serial_ctrl_clock_in, 2)) else $error("data changed outside clock low");
   chk_req_hold: assert property ($rose(host_read_request_n_oe_n_out) |=>
      host_read_request_n_oe_n_out [*5]) else $error("request released too briefly");
   chk_req_cause: assert property ($fell(host_read_request_n_oe_n_out) |->
      $past(tx_valid_in)) else $error("request without data");
   chk_mode_gate: assert property (autoload_active_out || !serial_mode_out |->
      serial_ctrl_data_io_oe_n_out && host_read_request_n_oe_n_out) else $error("bus used while disabled");
   chk_tx_pulse: assert property (tx_ready_out |-> tx_valid_in ##1 !tx_ready_out)
      else $error("outbound take not a single pulse");
   chk_rx_hold: assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out))
      else $error("received byte not held");

   cov_ack: cover property ($fell(serial_ctrl_data_io_oe_n_out));
   cov_release: cover property ($rose(host_read_request_n_oe_n_out));
   cov_rx: cover property (rx_valid_out && rx_ready_in);
endmodule

bind ihcp_top ihcp_top_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) mon (.clk_in, .reset_in, .serial_ctrl_clock_in,
   .serial_ctrl_data_io_oe_n_out, .host_read_request_n_oe_n_out, .serial_mode_out, .autoload_active_out,
   .rx_data_out, .rx_valid_out, .rx_ready_in, .tx_valid_in, .tx_ready_out);

/* bench/ihcp_host_model.sv */
// Purpose: Two-wire bus master model on the serial pins.
// Assumes: Eight clk_in cycles per bit; clock stands high between frames.
// Notes: Open drain: the model only pulls data low.
`timescale 1ns/100ps
module ihcp_host_model (
   // Clock
   input wire logic clk_in,
   // Resolved data wire
   input wire logic sda_in,
   // Driven lines
   output logic scl_out,
   output logic sda_low_out
);
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end

   // data set while clock low
   // Clock low five cycles: the port lets go of its acknowledge about four cycles after the fall
   task automatic bit_x(input logic b, output logic s);
      repeat (2) @(posedge clk_in);
      sda_low_out <= ~b;
      repeat (3) @(posedge clk_in);
      scl_out <= 1'b1;
      repeat (3) @(posedge clk_in);
      s = sda_in;
      scl_out <= 1'b0;
   endtask

   task automatic cond(input logic stop);
      repeat (2) @(posedge clk_in);
      sda_low_out <= stop;
      repeat (2) @(posedge clk_in);
      scl_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      sda_low_out <= ~stop;
      repeat (4) @(posedge clk_in);
      scl_out <= stop;
   endtask

   // whole bytes first bit most significant
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], s);
      end
      bit_x(1'b1, s);
      ack = (s === 1'b0);
   endtask

   task automatic rbyte(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, s);
         d[i] = s;
      end
      bit_x(1'b0, s);
   endtask
endmodule

/* bench/ihcp_top_tb.sv */
// Purpose: Self-checking bench of the serial host control port.
// Assumes: Host model is bus master; straps set during reset.
// Notes: Each scenario judges its own results.
`timescale 1ns/100ps
module ihcp_top_tb;
   import ihcp_pkg::*;
   logic clk_in = 1'b0, reset_in = 1'b1, autoload_done_in = 1'b0, cfg_write_in = 1'b0, ce_in = 1'b1;
   logic cfg_check_en_in = 1'b1, rx_ready_in = 1'b0, tx_valid_in = 1'b0;
   logic [2:0] straps = 3'h7;
   logic [6:0] cfg_addr_in = 7'h00;
   logic [7:0] tx_data_in = 8'h00;
   logic [7:0] tx_tab [3] = '{8'hA5, 8'h3C, 8'h81};
   int tx_idx = 0, fails = 0, compares = 0, cycles = 0;
   wire serial_ctrl_data_io_out, serial_ctrl_data_io_oe_n_out, host_read_request_n_out, scl, host_low;
   wire host_read_request_n_oe_n_out, serial_mode_out, autoload_active_out, rx_valid_out, tx_ready_out;
   wire [7:0] rx_data_out;
   // Pull-ups on both open-drain wires
   wire sda = ~host_low & (serial_ctrl_data_io_oe_n_out | serial_ctrl_data_io_out);
   wire req = host_read_request_n_oe_n_out | host_read_request_n_out;

   ihcp_top uut (.clk_in, .reset_in, .ce_in, .serial_ctrl_clock_in(scl), .serial_ctrl_data_io_in(sda),
      .serial_ctrl_data_io_out, .serial_ctrl_data_io_oe_n_out, .host_read_request_n_out,
      .host_read_request_n_oe_n_out, .mode_strap_output_enable_in(straps[2]),
      .mode_strap_write_strobe_in(straps[1]), .autoload_select_n_in(straps[0]), .autoload_done_in,
      .serial_mode_out, .autoload_active_out, .cfg_write_in, .cfg_check_en_in, .cfg_addr_in, .rx_data_out,
      .rx_valid_out, .rx_ready_in, .tx_data_in, .tx_valid_in, .tx_ready_out);
   ihcp_host_model host (.clk_in, .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));

   initial begin
      forever #50 clk_in = ~clk_in;
   end

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Outbound source pops on each take; also the run limit
   always @(posedge clk_in) begin
      cycles <= cycles + 1;
      if (tx_ready_out === 1'b1 && tx_valid_in) begin
         tx_idx <= tx_idx + 1;
         tx_valid_in <= (tx_idx < 2);
         tx_data_in <= tx_tab[(tx_idx + 1) % 3];
      end
      if (cycles == 60000) begin
         fails++;
         finish_test();
      end
   end

   task automatic do_reset(input logic [2:0] s);
      @(posedge clk_in);
      reset_in <= 1'b1;
      straps <= s;
      repeat (5) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (12) @(posedge clk_in);
   endtask

   // Waits for a byte, judges it, then takes it with a single ready cycle
   task automatic rx_take(input logic [7:0] e);
      int n = 0;
      rx_ready_in <= 1'b0;
      @(posedge clk_in);
      while (rx_valid_out !== 1'b1 && n < 300) begin
         n++;
         @(posedge clk_in);
      end
      check("rx valid", rx_valid_out, 1'b1);
      check("rx byte", rx_data_out, e);
      rx_ready_in <= 1'b1;
      @(posedge clk_in);
      rx_ready_in <= 1'b0;
   endtask

   task automatic probe(output logic a);
      host.cond(1'b0);
      host.wbyte(8'h00, a);
      host.cond(1'b1);
   endtask

   task automatic t_power();
      do_reset(3'h7);
      check("serial mode", serial_mode_out, 1'b1);
      check("request idle", req, 1'b1);
      check("data idle", sda, 1'b1);
      $display("test power done");
   endtask

   task automatic t_fill();
      logic a;
      int n = 0;
      rx_ready_in <= 1'b0;
      host.cond(1'b0);
      host.wbyte(8'h00, a);
      check("addr ack", a, 1'b1);
      for (int i = 0; i < 18; i++) begin
         host.wbyte(8'h96 ^ i[7:0], a);
         n += a;
      end
      check("accepted", n[7:0], 8'(IHCP_FIFO_DEPTH + 1));
      for (int i = 0; i < 17; i++) begin
         rx_take(8'h96 ^ i[7:0]);
      end
      host.wbyte(8'h96 ^ 8'h11, a);
      check("resend ack", a, 1'b1);
      host.cond(1'b1);
      rx_take(8'h96 ^ 8'h11);
      $display("test fill done");
   endtask

   task automatic t_addr();
      logic a;
      logic [15:0] tab [4];
      tab = '{{1'b1, 7'h00, 7'h05, 1'b0}, {1'b1, 7'h05, 7'h05, 1'b1}, {1'b0, 7'h05, 7'h33, 1'b1},
         {1'b1, 7'h00, 7'h00, 1'b1}};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_in);
         rx_ready_in <= 1'b0;
         cfg_write_in <= 1'b1;
         {cfg_check_en_in, cfg_addr_in} <= tab[i][15:8];
         @(posedge clk_in);
         cfg_write_in <= 1'b0;
         host.cond(1'b0);
         host.wbyte({tab[i][7:1], 1'b0}, a);
         check("addr ack", a, tab[i][0]);
         host.wbyte(8'hC3 ^ i[7:0], a);
         check("data ack", a, tab[i][0]);
         host.cond(1'b1);
         if (tab[i][0]) begin
            rx_take(8'hC3 ^ i[7:0]);
         end else begin
            check("dropped", rx_valid_out, 1'b0);
         end
      end
      $display("test address done");
   endtask

   task automatic t_read();
      logic a;
      logic [7:0] d;
      int n = 0;
      @(posedge clk_in);
      tx_idx <= 0;
      tx_data_in <= tx_tab[0];
      tx_valid_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      check("request", req, 1'b0);
      host.cond(1'b0);
      host.wbyte(8'h01, a);
      check("read addr ack", a, 1'b1);
      do begin
         host.rbyte(d);
         check("read byte", d, tx_tab[n % 3]);
         n++;
      end while (req === 1'b0 && n < 5);
      check("read count", n[7:0], 8'h03);
      host.cond(1'b1);
      check("request off", req, 1'b1);
      $display("test read done");
   endtask

   // Clock enable low freezes the port, so a whole frame passes unanswered
   task automatic t_ce();
      logic a;
      @(posedge clk_in);
      ce_in <= 1'b0;
      probe(a);
      check("frozen ack", a, 1'b0);
      check("frozen request", req, 1'b1);
      @(posedge clk_in);
      ce_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      probe(a);
      check("thawed ack", a, 1'b1);
      $display("test enable done");
   endtask

   task automatic t_mode();
      logic a;
      do_reset(3'h6);
      check("autoload on", autoload_active_out, 1'b1);
      repeat (20) @(posedge clk_in);
      autoload_done_in <= 1'b1;
      @(posedge clk_in);
      autoload_done_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      check("autoload off", autoload_active_out, 1'b0);
      probe(a);
      check("ack after load", a, 1'b1);
      do_reset(3'h3);
      check("parallel mode", serial_mode_out, 1'b0);
      probe(a);
      check("ignored", a, 1'b0);
      do_reset(3'h7);
      $display("test mode done");
   endtask

   initial begin
      t_power();
      t_fill();
      t_addr();
      t_read();
      t_ce();
      t_mode();
      finish_test();
   end
endmodule
